/* rtl/ebp_map.svh */
// Purpose: register offsets, field positions, codes and reset values of the bridge pwm
// Assumes: byte addresses on a 32-bit wishbone bus, one aligned word per register
// Notes: definitions only
`ifndef EBP_MAP_SVH
`define EBP_MAP_SVH

// register byte offsets
`define EBP_ADR_CTRL 8'h00
`define EBP_ADR_PERIOD 8'h04
`define EBP_ADR_DUTY 8'h08
`define EBP_ADR_SHADOW 8'h0C
`define EBP_ADR_DELAY 8'h10
`define EBP_ADR_TCTL 8'h14
`define EBP_ADR_STATUS 8'h18

// capture_pwm_control_reg fields
`define EBP_CTRL_CFG 7:6
`define EBP_CTRL_CFG_DIR 7
`define EBP_CTRL_CFG_FULL 6
`define EBP_CTRL_DLSB 5:4
`define EBP_CTRL_PWMSEL 3:2
`define EBP_CTRL_POL 1:0
// polarity bit positions inside the low mode bits
`define EBP_POL_AC 1
`define EBP_POL_BD 0

// timer_control_reg fields
`define EBP_TCTL_ON 2
`define EBP_TCTL_PS 1:0

// output_config_field codes
`define EBP_CFG_SINGLE 2'h0
`define EBP_CFG_HALF 2'h2
`define EBP_CFG_FWD 2'h1
`define EBP_CFG_REV 2'h3

// mode_select_field upper pair that means pwm
`define EBP_MODE_PWM 2'h3

// timer_prescale_select codes, anything else divides by 16
`define EBP_PS_1 2'h0
`define EBP_PS_4 2'h1

// reset values
`define EBP_CTRL_RST 8'h00
`define EBP_PERIOD_RST 8'hFF
`define EBP_DUTY_RST 8'h00
`define EBP_DELAY_RST 7'h00
`define EBP_TCTL_RST 3'h0

// one instruction cycle is four oscillator periods, one clk_sys each
`define EBP_CLK_PER_TCY 9'h004

`endif

/* rtl/ebp_pkg.sv */
// Purpose: types of the bridge pwm
// Assumes: nothing
// Notes: constants live in ebp_map.svh
package ebp_pkg;

   // run state of the output stage
   typedef enum logic [1:0] {
      EBP_IDLE,
      EBP_WAIT,
      EBP_RUN
   } ebp_state_t;

   // every flip-flop of the block
   typedef struct packed {
      ebp_state_t state;
      logic [7:0] ctrl;
      logic [7:0] period;
      logic [7:0] duty;
      logic [6:0] delay;
      logic [2:0] tctl;
      logic [1:0] cfg_cur;
      logic [1:0] pol_cur;
      logic [7:0] pr_cur;
      logic [9:0] shadow;
      logic [6:0] dly_cur;
      logic [5:0] pcnt;
      logic [7:0] tmr;
      logic pwm;
      logic [8:0] dcnt;
      logic out_a;
      logic out_b;
      logic out_c;
      logic out_d;
      logic ack;
      logic [31:0] rdat;
   } ebp_st_t;

endpackage : ebp_pkg

/* rtl/ebp_bridge_pwm.sv */
// Purpose: enhanced bridge pwm with period timer, deadband and direction control
// Assumes: one clk_sys period stands for one oscillator period
// Notes: registers over classic wishbone, all outputs registered
// Operation
// - config from bits 7:6, polarity from 1:0
// - settings take effect at period start, the delay copy also at the duty boundary; leaving pwm mode parks the legs at once
// - delay copy loads at duty or period boundary
// - enabled output waits for first timer reset
// - period is (period+1) times 4 times prescale
// - period match clears timer, sets output, loads duty
// - no postscaler in period arithmetic
// - duty is byte plus two control bits
// - active time is duty times prescale clocks
// - duty writes anytime, shadow is read only
// - output clears when extended timer equals duty
// - duty beyond period never clears output
// - four arrangements: single, half, forward, reverse
// - half bridge drives pwm and its complement
// - half bridge delays each rising edge
// - delay longer than active keeps output inactive
// - full bridge holds one, modulates opposite leg
// - new direction starts with next period
// - direction swap one timer step before period
// - prescaler divides by 1, 4 or 16
// - full bridge uses no deadband
// - mode 11xx selects pwm and polarities
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "ebp_map.svh"

module ebp_bridge_pwm (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic bridge_out_a,
   output logic bridge_out_b,
   output logic bridge_out_c,
   output logic bridge_out_d
);

   // whole state and its next value
   ebp_pkg::ebp_st_t st_ff;
   ebp_pkg::ebp_st_t nxt_st;

   // bus request decode
   logic req;
   logic wr_lo;
   logic [7:0] word; // word index, as wide as the offsets it is decoded against
   logic [31:0] rd_val;

   // live software settings
   logic [1:0] live_cfg;
   logic [9:0] live_duty;
   logic live_pwm;
   logic [1:0] live_pol;

   // timer helpers
   logic timer_on;
   logic [1:0] ps_sel;
   logic [5:0] pc_inc;
   logic [5:0] nxt_pc;
   logic [1:0] nxt_sub;
   logic tick;
   logic wrap;
   logic [7:0] nxt_tmr;
   logic match;

   // output stage helpers
   logic dly_done;
   logic dir_chg;
   logic [1:0] pol;
   logic act_a;
   logic act_b;
   logic act_c;
   logic act_d;

   // a request is taken once; ack drops in the cycle after it was given
   assign req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
   // all writable registers are at most a byte wide, lane 0 carries them
   assign wr_lo = req & wb_we_i & wb_sel_i[0];
   assign word = {2'h0, wb_adr_i[7:2]};

   // settings as software wrote them, not yet applied
   assign live_cfg = st_ff.ctrl[`EBP_CTRL_CFG];
   assign live_duty = {st_ff.duty, st_ff.ctrl[`EBP_CTRL_DLSB]};
   assign live_pwm = (st_ff.ctrl[`EBP_CTRL_PWMSEL] == `EBP_MODE_PWM);
   assign live_pol = st_ff.ctrl[`EBP_CTRL_POL];

   // prescaler counts oscillator periods; no postscaler exists here
   assign timer_on = st_ff.tctl[`EBP_TCTL_ON];
   assign ps_sel = st_ff.tctl[`EBP_TCTL_PS];
   assign pc_inc = st_ff.pcnt + 6'h01;
   assign nxt_pc = timer_on ? pc_inc : 6'h00;

   // timer step every 4, 16 or 64 clocks: 4 Tosc times prescale
   always_comb begin
      case (ps_sel)
         `EBP_PS_1: tick = timer_on & (st_ff.pcnt[1:0] == 2'h3);
         `EBP_PS_4: tick = timer_on & (st_ff.pcnt[3:0] == 4'hF);
         default: tick = timer_on & (st_ff.pcnt == 6'h3F);
      endcase
   end

   // two sub-step bits extend the timer to ten bits for the duty compare
   always_comb begin
      case (ps_sel)
         `EBP_PS_1: nxt_sub = nxt_pc[1:0];
         `EBP_PS_4: nxt_sub = nxt_pc[3:2];
         default: nxt_sub = nxt_pc[5:4];
      endcase
   end

   // period ends on the step after the timer equals the period copy
   assign wrap = tick & (st_ff.tmr == st_ff.pr_cur);

   // timer clears on wrap, holds while stopped
   always_comb begin
      if (wrap) begin
         nxt_tmr = 8'h00;
      end else if (tick) begin
         nxt_tmr = st_ff.tmr + 8'h01;
      end else begin
         nxt_tmr = st_ff.tmr;
      end
   end

   // duty compare against the count of the coming cycle, so that the
   // active time is exactly duty times prescale clocks
   assign match = ({nxt_tmr, nxt_sub} == st_ff.shadow);

   // register read mux; unmapped words read as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (word)
         `EBP_ADR_CTRL >> 2: rd_val[7:0] = st_ff.ctrl;
         `EBP_ADR_PERIOD >> 2: rd_val[7:0] = st_ff.period;
         `EBP_ADR_DUTY >> 2: rd_val[7:0] = st_ff.duty;
         `EBP_ADR_SHADOW >> 2: rd_val[7:0] = st_ff.shadow[9:2];
         `EBP_ADR_DELAY >> 2: rd_val[6:0] = st_ff.delay;
         `EBP_ADR_TCTL >> 2: rd_val[2:0] = st_ff.tctl;
         `EBP_ADR_STATUS >> 2: begin
            // timer count, running flag and applied direction
            rd_val[7:0] = st_ff.tmr;
            rd_val[8] = (st_ff.state == ebp_pkg::EBP_RUN);
            rd_val[9] = st_ff.cfg_cur[1];
            rd_val[10] = st_ff.pwm;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // next state of everything
   always_comb begin
      nxt_st = st_ff;
      act_a = 1'h0;
      act_b = 1'h0;
      act_c = 1'h0;
      act_d = 1'h0;
      dly_done = 1'h0;
      dir_chg = 1'h0;
      pol = 2'h0;

      // bus handshake: one wait state, ack for any address
      nxt_st.ack = req;
      if (req & ~wb_we_i) begin
         nxt_st.rdat = rd_val;
      end

      // register writes; the shadow and status words ignore writes
      if (wr_lo) begin
         case (word)
            `EBP_ADR_CTRL >> 2: nxt_st.ctrl = wb_dat_i[7:0];
            `EBP_ADR_PERIOD >> 2: nxt_st.period = wb_dat_i[7:0];
            `EBP_ADR_DUTY >> 2: nxt_st.duty = wb_dat_i[7:0];
            `EBP_ADR_DELAY >> 2: nxt_st.delay = wb_dat_i[6:0];
            `EBP_ADR_TCTL >> 2: nxt_st.tctl = wb_dat_i[2:0];
            default: nxt_st.tctl = nxt_st.tctl; // read only or unmapped
         endcase
      end

      // period timer and prescaler
      nxt_st.pcnt = nxt_pc;
      nxt_st.tmr = nxt_tmr;

      // run state
      case (st_ff.state)
         ebp_pkg::EBP_IDLE: begin
            // outputs parked; period follows software directly
            nxt_st.pr_cur = st_ff.period;
            nxt_st.pwm = 1'h0;
            if (live_pwm) begin
               nxt_st.state = ebp_pkg::EBP_WAIT;
            end
         end
         ebp_pkg::EBP_WAIT: begin
            // buffered outputs cannot start before a timer reset
            nxt_st.pr_cur = st_ff.period;
            nxt_st.pwm = 1'h0;
            if (!live_pwm) begin
               nxt_st.state = ebp_pkg::EBP_IDLE;
            end else if (wrap) begin
               nxt_st.state = ebp_pkg::EBP_RUN;
            end
         end
         ebp_pkg::EBP_RUN: begin
            if (!live_pwm) begin
               // leaving pwm parks at once rather than at the boundary
               nxt_st.state = ebp_pkg::EBP_IDLE;
               nxt_st.pwm = 1'h0;
            end else if (!wrap && match && st_ff.pwm) begin
               // duty boundary; a duty past the period never matches
               nxt_st.pwm = 1'h0;
               nxt_st.dly_cur = st_ff.delay;
            end
         end
         default: nxt_st.state = ebp_pkg::EBP_IDLE;
      endcase

      // period boundary: apply every buffered setting together
      if (live_pwm && wrap && (st_ff.state != ebp_pkg::EBP_IDLE)) begin
         nxt_st.cfg_cur = live_cfg;
         nxt_st.pol_cur = live_pol;
         nxt_st.pr_cur = st_ff.period;
         nxt_st.shadow = live_duty;
         nxt_st.dly_cur = st_ff.delay;
         // zero duty leaves the output clear for the whole period
         nxt_st.pwm = (live_duty != 10'h000);
      end

      // deadband counter restarts on every pwm edge and saturates
      if (nxt_st.state != ebp_pkg::EBP_RUN) begin
         nxt_st.dcnt = 9'h000;
      end else if (nxt_st.pwm != st_ff.pwm) begin
         nxt_st.dcnt = 9'h000;
      end else if (st_ff.dcnt != 9'h1FF) begin
         nxt_st.dcnt = st_ff.dcnt + 9'h001;
      end

      // delay is counted in instruction cycles of four clocks; the
      // next edge restarts the count, so a long delay never finishes
      dly_done = (nxt_st.dcnt >= ({2'h0, nxt_st.dly_cur} * `EBP_CLK_PER_TCY));

      // direction request seen in the last timer step of a full bridge period
      dir_chg = nxt_st.cfg_cur[0] & live_cfg[0]
         & (live_cfg[1] != nxt_st.cfg_cur[1])
         & timer_on & (nxt_st.tmr == nxt_st.pr_cur);

      // output arrangement, in active terms
      if (nxt_st.state == ebp_pkg::EBP_RUN) begin
         case (nxt_st.cfg_cur)
            `EBP_CFG_SINGLE: begin
               act_a = nxt_st.pwm;
            end
            `EBP_CFG_HALF: begin
               // each leg turns on only after the deadband
               act_a = nxt_st.pwm & dly_done;
               act_b = ~nxt_st.pwm & dly_done;
            end
            `EBP_CFG_FWD: begin
               if (dir_chg) begin
                  // modulated legs off, held leg already swapped
                  act_c = 1'h1;
               end else begin
                  act_a = 1'h1;
                  act_d = nxt_st.pwm;
               end
            end
            `EBP_CFG_REV: begin
               if (dir_chg) begin
                  act_a = 1'h1;
               end else begin
                  act_c = 1'h1;
                  act_b = nxt_st.pwm;
               end
            end
            default: act_a = 1'h0;
         endcase
      end

      // polarity: applied copy while running, live bits while waiting
      if (nxt_st.state == ebp_pkg::EBP_RUN) begin
         pol = nxt_st.pol_cur;
      end else if (live_pwm) begin
         pol = live_pol;
      end else begin
         pol = 2'h0;
      end

      nxt_st.out_a = act_a ^ pol[`EBP_POL_AC];
      nxt_st.out_c = act_c ^ pol[`EBP_POL_AC];
      nxt_st.out_b = act_b ^ pol[`EBP_POL_BD];
      nxt_st.out_d = act_d ^ pol[`EBP_POL_BD];

      // synchronous reset: constants only
      if (!rst_n) begin
         nxt_st = '0;
         nxt_st.state = ebp_pkg::EBP_IDLE;
         nxt_st.ctrl = `EBP_CTRL_RST;
         nxt_st.period = `EBP_PERIOD_RST;
         nxt_st.pr_cur = `EBP_PERIOD_RST;
         nxt_st.duty = `EBP_DUTY_RST;
         nxt_st.delay = `EBP_DELAY_RST;
         nxt_st.tctl = `EBP_TCTL_RST;
      end
   end

   // single state register
   always_ff @(posedge clk_sys) begin
      st_ff <= nxt_st;
   end

   // ports straight from the state register
   assign wb_dat_o = st_ff.rdat;
   assign wb_ack_o = st_ff.ack;
   assign bridge_out_a = st_ff.out_a;
   assign bridge_out_b = st_ff.out_b;
   assign bridge_out_c = st_ff.out_c;
   assign bridge_out_d = st_ff.out_d;

endmodule : ebp_bridge_pwm

/* sim/ebp_bridge_pwm_checker.sv */
// Purpose: port checks of the bridge pwm
// Assumes: control writes land at the edge that takes them
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module ebp_bridge_pwm_checker (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic bridge_out_a,
   input wire logic bridge_out_b,
   input wire logic bridge_out_c,
   input wire logic bridge_out_d
);
   logic [7:0] ctrl_ff; // control byte as software left it
   logic [3:0] outs; // legs a to d
   assign outs = {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d};
   // mirror control writes, the legs hang on them
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_ff <= 8'h00;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
            && wb_adr_i[7:2] == 6'h00) begin
         ctrl_ff <= wb_dat_i[7:0];
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   a_ack_pulse: assert property (disable iff (!rst_n) wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   a_ack_answer: assert property (disable iff (!rst_n)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_cause: assert property (disable iff (!rst_n)
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_hold: assert property (disable iff (!rst_n)
      $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
      else $error("read data moved outside a read ack");
   a_reset_quiet: assert property (!rst_n |=> !wb_ack_o && outs == 4'h0 && wb_dat_o == 32'h0)
      else $error("reset left something driven");
   a_off_parks: assert property (disable iff (!rst_n)
      (ctrl_ff[3:2] != 2'h3) [*3] |-> outs == 4'h0)
      else $error("legs driven outside pwm mode");
   a_rise_mode: assert property (disable iff (!rst_n)
      $rose(bridge_out_a) |-> $past(ctrl_ff[3:2]) == 2'h3)
      else $error("leg a rose outside pwm mode");
   a_half_apart: assert property (disable iff (!rst_n)
      ctrl_ff[7:6] == 2'h2 && ctrl_ff[1:0] == 2'h0 |-> !(bridge_out_a && bridge_out_b))
      else $error("half bridge legs active together");
   c_half: cover property (disable iff (!rst_n) ctrl_ff[7:6] == 2'h2 && $rose(bridge_out_b));
   c_full: cover property (disable iff (!rst_n) $rose(bridge_out_d));
   c_read: cover property (disable iff (!rst_n) wb_ack_o && !wb_we_i);
endmodule : ebp_bridge_pwm_checker

bind ebp_bridge_pwm ebp_bridge_pwm_checker i_chk (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bridge_out_a,
   .bridge_out_b, .bridge_out_c, .bridge_out_d);

/* sim/ebp_drv_model.sv */
// Purpose: switch driver stand-in that times one leg
// Assumes: the timed leg is taken as active high
// Notes: reports high time and period at each rise
`timescale 1ns/1ps
module ebp_drv_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic bridge_out_a,
   input wire logic bridge_out_b,
   input wire logic bridge_out_c,
   input wire logic bridge_out_d,
   input wire logic [1:0] leg_sel,
   output logic [15:0] hi_len,
   output logic [15:0] per_len,
   output logic meas
);
   logic [15:0] hi_ff; // high cycles since last rise
   logic [15:0] cnt_ff; // cycles since last rise
   logic seen_ff; // counts are whole only after one rise
   logic last_ff; // leg one cycle back
   logic [3:0] legs; // legs d to a
   assign legs = {bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a};
   // a switch only sees edges, so time rise to rise
   always_ff @(posedge clk_sys) begin
      last_ff <= legs[leg_sel];
      meas <= 1'b0;
      if (!rst_n) begin
         seen_ff <= 1'b0;
         cnt_ff <= 16'h0000;
         hi_ff <= 16'h0000;
      end else if (legs[leg_sel] && !last_ff) begin
         meas <= seen_ff;
         hi_len <= hi_ff;
         per_len <= cnt_ff;
         seen_ff <= 1'b1;
         cnt_ff <= 16'h0001;
         hi_ff <= 16'h0001;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
         hi_ff <= hi_ff + {15'h0000, legs[leg_sel]};
      end
   end
endmodule : ebp_drv_model

/* sim/ebp_bridge_pwm_test.sv */
// Purpose: self-checking bench of the bridge pwm
// Assumes: one clk_sys period is one oscillator period
// Notes: reads and leg timings are queued, a monitor checks them
`timescale 1ns/1ps
`include "ebp_map.svh"
module ebp_bridge_pwm_test;
   logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, meas;
   logic bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [1:0] leg_sel;
   logic [15:0] hi_len, per_len;
   logic [31:0] rq[$]; // expected read data
   logic [31:0] mq[$]; // expected high time and period
   int mismatches, comparisons;
   ebp_bridge_pwm i_dut (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bridge_out_a, .bridge_out_b,
      .bridge_out_c, .bridge_out_d);
   // legs wired straight into the drivers, so every used pin acts as an output
   ebp_drv_model i_drv (.clk_sys, .rst_n, .bridge_out_a, .bridge_out_b, .bridge_out_c,
      .bridge_out_d, .leg_sel, .hi_len, .per_len, .meas);
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      comparisons++;
      if (seen !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      if (n >= 20) tally_and_finish();
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask : wb
   task automatic rd(input logic [7:0] adr, input logic [31:0] e);
      rq.push_back(e);
      wb(1'b0, adr, 32'h0);
   endtask : rd
   // let the leg settle three periods, then queue what the next one must be
   task automatic tl(input logic [1:0] l, input int hi, input int per);
      int n, k;
      leg_sel <= l;
      k = 0;
      for (n = 0; n < 9000 && !(k > 3 && mq.size() == 0); n++) begin
         @(posedge clk_sys);
         if (k == 3) mq.push_back({hi[15:0], per[15:0]});
         k = (k == 3) ? 4 : k + int'(meas === 1'b1);
      end
      if (n >= 9000) mismatches++;
      if (n >= 9000) tally_and_finish();
   endtask : tl
   // cycles until leg l (0 is a, 3 is d) next rises, bounded
   task automatic rise(input int l, output int n);
      logic [3:0] prv;
      logic [3:0] now;
      now = {bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a};
      prv = now;
      n = 0;
      while (!(now[l] && !prv[l]) && n < 200) begin
         @(posedge clk_sys);
         prv = now;
         now = {bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a};
         n++;
      end
      if (n >= 200) mismatches++;
      if (n >= 200) tally_and_finish();
   endtask : rise
   // legs under mask must sit at a fixed level for many periods
   task automatic lvl(input logic [3:0] mask, input logic [3:0] e);
      logic [3:0] o;
      o = 4'h0;
      repeat (80) @(posedge clk_sys);
      repeat (80) begin
         @(posedge clk_sys);
         o = o | (({bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} ^ e) & mask);
      end
      chk("levels", {28'h0, o}, 32'h0);
   endtask : lvl
   // monitor: every result is checked the cycle it shows
   always @(posedge clk_sys) begin
      logic [31:0] e;
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0) begin
         chk("read", wb_dat_o, rq.pop_front());
      end
      if (meas === 1'b1 && mq.size() > 0) begin
         e = mq.pop_front();
         chk("high", {16'h0, hi_len}, {16'h0, e[31:16]});
         chk("period", {16'h0, per_len}, {16'h0, e[15:0]});
      end
   end
   initial begin
      int p, d, s, m, n;
      {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, leg_sel} = '0;
      wb_sel_i = 4'hF;
      mismatches = 0;
      comparisons = 0;
      p = $urandom(32'h3392c228);
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      chk("outs", {28'h0, bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d}, 0);
      rd(`EBP_ADR_CTRL, 32'h0);
      // a write without lane 0 is acked but must leave the period untouched
      wb_sel_i <= 4'hE;
      wb(1'b1, `EBP_ADR_PERIOD, 32'h3);
      wb_sel_i <= 4'hF;
      rd(`EBP_ADR_PERIOD, 32'hFF);
      rd(8'h1C, 32'h0);
      // random period and duty at each prescale
      for (s = 0; s < 3; s++) begin
         p = $urandom_range(7, 1);
         d = $urandom_range(p * 4 + 3, 1);
         wb(1'b1, `EBP_ADR_PERIOD, p);
         wb(1'b1, `EBP_ADR_DUTY, d >> 2);
         wb(1'b1, `EBP_ADR_CTRL, {26'h0, d[1:0], 4'hC});
         wb(1'b1, `EBP_ADR_TCTL, 32'h4 | s);
         tl(2'h0, d << (2 * s), (p + 1) << (2 * s + 2));
      end
      wb(1'b1, `EBP_ADR_TCTL, 32'h4);
      wb(1'b1, `EBP_ADR_PERIOD, 32'h7);
      wb(1'b1, `EBP_ADR_SHADOW, 32'hFF);
      rd(`EBP_ADR_SHADOW, d >> 2);
      wb(1'b1, `EBP_ADR_DUTY, 32'h0);
      wb(1'b1, `EBP_ADR_CTRL, 32'h0C);
      lvl(4'h8, 4'h0);
      wb(1'b1, `EBP_ADR_DUTY, 32'hFF);
      wb(1'b1, `EBP_ADR_CTRL, 32'h3C);
      lvl(4'h8, 4'h8);
      // half bridge, duty 20 of 32, deadband 8 then 16 clocks
      wb(1'b1, `EBP_ADR_DUTY, 32'h5);
      wb(1'b1, `EBP_ADR_DELAY, 32'h2);
      wb(1'b1, `EBP_ADR_CTRL, 32'h8C);
      tl(2'h0, 12, 32);
      tl(2'h1, 4, 32);
      wb(1'b1, `EBP_ADR_DELAY, 32'h4);
      tl(2'h0, 4, 32);
      lvl(4'h4, 4'h0);
      // full bridge keeps the deadband setting but must ignore it
      wb(1'b1, `EBP_ADR_CTRL, 32'h4C);
      tl(2'h3, 20, 32);
      lvl(4'hE, 4'h8);
      wb(1'b1, `EBP_ADR_DUTY, 32'h1);
      // reverse early in a period, so the whole last timer step is the changeover
      rise(3, n);
      wb(1'b1, `EBP_ADR_CTRL, 32'hCC);
      rise(2, n);
      chk("swap legs", {30'h0, bridge_out_a, bridge_out_d}, 32'h0);
      rise(1, n);
      chk("swap lead", n, 4);
      tl(2'h1, 4, 32);
      lvl(4'hB, 4'h2);
      for (m = 0; m < 4; m++) begin
         wb(1'b1, `EBP_ADR_CTRL, 32'hCC | m);
         lvl(4'hB, {m[1], 1'b0, ~m[1], m[0]});
      end
      wb(1'b1, `EBP_ADR_CTRL, 32'h0);
      lvl(4'hF, 4'h0);
      tally_and_finish();
   end
endmodule : ebp_bridge_pwm_test
